// ---- src/uvr_fault_response.sv ----
`default_nettype none
module uvr_fault_response
  import uvr_pkg::*;
#(
  parameter int DELAY_STEP = DELAY_STEP_CYCLES
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic respWrite,
  input wire logic [7:0] respWriteData,
  output logic [7:0] undervoltage_response_byte,
  input wire logic clearFaults,
  input wire logic runPin,
  input wire logic operationOn,
  input wire logic uvDetect,
  input wire logic rampActive,
  input wire logic otherFaultNoRetry,
  input wire logic [7:0] retry_interval_setting,
  output logic outputEnable,
  output logic uvFaultBit,
  output logic cmlFault,
  output logic smbAlertOut,
  output logic smbAlertOe
);

  logic [1:0] runSync;
  logic [1:0] uvSync;
  logic runOnPrev;
  logic [7:0] next_respByte;
  logic next_cmlFault;
  uvr_state_t state;
  uvr_state_t next_state;
  logic [WAIT_WIDTH-1:0] waitCount;
  logic [WAIT_WIDTH-1:0] next_waitCount;
  logic next_uvFaultBit;
  logic next_outputEnable;

  logic runOn;
  logic uvSeen;
  logic restartEdge;
  logic [1:0] respCode;
  logic [2:0] retryCode;
  logic [2:0] delayCode;
  logic [WAIT_WIDTH-1:0] delayLoad;
  logic [WAIT_WIDTH-1:0] retryLoad;

  assign respCode = undervoltage_response_byte[RESP_MSB:RESP_LSB];
  assign retryCode = undervoltage_response_byte[RETRY_MSB:RETRY_LSB];
  assign delayCode = undervoltage_response_byte[DELAY_MSB:DELAY_LSB];
  assign runOn = runSync[1] & operationOn;
  assign restartEdge = runOn & ~runOnPrev;
  // Only live while the output is up and not ramping
  assign uvSeen = uvSync[1] & runOn & ~rampActive
    & ((state == UVR_RUN) | (state == UVR_DELAY));
  assign delayLoad = WAIT_WIDTH'(delayCode * DELAY_STEP);
  assign retryLoad = WAIT_WIDTH'(retry_interval_setting * DELAY_STEP);

  // Pins cross into the clock domain before anything looks at them
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      runSync <= 2'h0;
      uvSync <= 2'h0;
      runOnPrev <= 1'b0;
    end else begin
      runSync <= {runSync[0], runPin};
      uvSync <= {uvSync[0], uvDetect};
      runOnPrev <= runOn;
    end
  end

  // Byte-wide configuration store
  always_comb begin
    next_respByte = undervoltage_response_byte;
    next_cmlFault = 1'b0;
    if (respWrite) begin
      if (respWriteData[RESP_MSB:RESP_LSB] == RESP_UNSUPPORTED) begin
        next_cmlFault = 1'b1;
      end else begin
        next_respByte = respWriteData;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      undervoltage_response_byte <= RESP_BYTE_RESET;
      cmlFault <= 1'b0;
    end else begin
      undervoltage_response_byte <= next_respByte;
      cmlFault <= next_cmlFault;
    end
  end

  config_store_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (respWrite && respWriteData[RESP_MSB:RESP_LSB] != RESP_UNSUPPORTED) |=>
      (undervoltage_response_byte == $past(respWriteData) && !cmlFault))
    else $error("accepted byte not stored");

  config_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !respWrite |=> $stable(undervoltage_response_byte))
    else $error("stored byte moved without a write");

  refusal_pulse_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (cmlFault && !respWrite) |=> !cmlFault)
    else $error("refusal flag outlived its write");

  // Response sequencer
  always_comb begin
    next_state = state;
    next_waitCount = waitCount;
    if (!runOn) begin
      next_state = UVR_OFF;
    end else begin
      unique case (state)
        UVR_OFF: begin
          next_state = UVR_RUN;
        end
        UVR_RUN: begin
          if (uvSeen) begin
            if (respCode == RESP_DELAYED) begin
              next_state = UVR_DELAY;
              next_waitCount = delayLoad;
            end else if (respCode == RESP_SHUTDOWN) begin
              if (retryCode == RETRY_FOREVER && !otherFaultNoRetry) begin
                next_state = UVR_RETRY;
                next_waitCount = retryLoad;
              end else begin
                next_state = UVR_LATCHED;
              end
            end
            // RESP_IGNORE keeps regulating
          end
        end
        UVR_DELAY: begin
          if (!uvSeen) begin
            next_state = UVR_RUN;
          end else if (waitCount == '0) begin
            if (retryCode == RETRY_FOREVER && !otherFaultNoRetry) begin
              next_state = UVR_RETRY;
              next_waitCount = retryLoad;
            end else begin
              next_state = UVR_LATCHED;
            end
          end else begin
            next_waitCount = waitCount - 1'b1;
          end
        end
        UVR_LATCHED: begin
          // Codes other than 000 and 111 are treated as no retry
          if (clearFaults) begin
            next_state = UVR_RUN;
          end
        end
        UVR_RETRY: begin
          if (otherFaultNoRetry) begin
            next_state = UVR_LATCHED;
          end else if (waitCount == '0) begin
            next_state = UVR_RUN;
          end else begin
            next_waitCount = waitCount - 1'b1;
          end
        end
        default: begin
          next_state = UVR_OFF;
        end
      endcase
    end
    next_outputEnable = (next_state == UVR_RUN) | (next_state == UVR_DELAY);
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state <= UVR_OFF;
      waitCount <= '0;
      outputEnable <= 1'b0;
    end else begin
      state <= next_state;
      waitCount <= next_waitCount;
      outputEnable <= next_outputEnable;
    end
  end

  // Leaving the delay wait early or late, or the retry wait late, shows up here
  delay_holds_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state == UVR_DELAY && uvSeen && waitCount != '0) |=>
      (state == UVR_DELAY && outputEnable))
    else $error("delay left before it expired");

  delay_acts_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state == UVR_DELAY && uvSeen && waitCount == '0) |=> !outputEnable)
    else $error("fault outlasted the delay but output stayed on");

  retry_restart_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state == UVR_RETRY && waitCount == '0 && runOn && !otherFaultNoRetry) |=>
      (state == UVR_RUN && outputEnable))
    else $error("retry wait ended without a restart");

  sequence retryEntered_s;
    state != UVR_RETRY ##1 state == UVR_RETRY;
  endsequence

  retry_load_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    retryEntered_s |->
      waitCount == WAIT_WIDTH'($past(retry_interval_setting) * DELAY_STEP))
    else $error("retry wait not taken from the interval setting");

  ramp_holds_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state == UVR_RUN && runOn && rampActive) |=> state == UVR_RUN)
    else $error("fault acted during an output ramp");

  off_forces_idle_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !runOn |=> (state == UVR_OFF && !outputEnable))
    else $error("output kept running while commanded off");

  // Status bit: a fault in the clearing cycle still lands
  always_comb begin
    next_uvFaultBit = uvFaultBit;
    if (clearFaults || restartEdge) begin
      next_uvFaultBit = 1'b0;
    end
    if (uvSeen) begin
      next_uvFaultBit = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      uvFaultBit <= 1'b0;
    end else begin
      uvFaultBit <= next_uvFaultBit;
    end
  end

  clear_drops_bit_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (clearFaults && !uvSeen) |=> !uvFaultBit)
    else $error("clear-faults left the bit set");

  restart_clears_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    ($rose(runOn) && !uvSeen) |=> !uvFaultBit)
    else $error("off-on cycle left the bit set");

  // Open-drain alert: pulled low while the fault is pending
  assign smbAlertOut = 1'b0;
  assign smbAlertOe = uvFaultBit;

  sequence faultHit_s;
    uvSeen && respCode == RESP_SHUTDOWN && state == UVR_RUN;
  endsequence

  sequence outputDrops_s;
    ##1 !outputEnable;
  endsequence

  ignore_keeps_on_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state == UVR_RUN && respCode == RESP_IGNORE && runOn) |=> outputEnable)
    else $error("ignore response dropped the output");

  delay_entered_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state == UVR_RUN && uvSeen && respCode == RESP_DELAYED) |=>
      (state == UVR_DELAY && waitCount == $past(delayLoad)))
    else $error("delayed response did not load the delay");

  shutdown_now_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    faultHit_s |-> outputDrops_s)
    else $error("shutdown response kept the output on");

  bad_code_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (respWrite && respWriteData[7:6] == RESP_UNSUPPORTED) |=>
      (cmlFault && undervoltage_response_byte == $past(undervoltage_response_byte)))
    else $error("unsupported code not refused");

  status_set_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    uvSeen |=> uvFaultBit)
    else $error("fault bit not set");

  alert_follows_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    uvSeen |=> smbAlertOe && !smbAlertOut)
    else $error("alert not asserted");

  bit_sticky_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (uvFaultBit && !clearFaults && !restartEdge) |=> uvFaultBit)
    else $error("fault bit cleared without cause");

  no_retry_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state == UVR_LATCHED && runOn && !clearFaults) |=> (state == UVR_LATCHED && !outputEnable))
    else $error("latched shutdown restarted");

  other_stops_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (state == UVR_RETRY && otherFaultNoRetry && runOn) |=> state == UVR_LATCHED)
    else $error("retry continued after no-retry fault");

  masked_off_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!runOn || rampActive) |-> !uvSeen)
    else $error("detection not masked");

endmodule
`default_nettype wire

// ---- src/uvr_pkg.sv ----
`default_nettype none
package uvr_pkg;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int DELAY_STEP_US = 10;
  localparam int DELAY_STEP_CYCLES = (DELAY_STEP_US * 1000000) / CLK_PERIOD_PS;
  localparam logic [7:0] RESP_BYTE_RESET = 8'h00;
  localparam int RESP_MSB = 7;
  localparam int RESP_LSB = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int DELAY_MSB = 2;
  localparam int DELAY_LSB = 0;
  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_DELAYED = 2'h1;
  localparam logic [1:0] RESP_SHUTDOWN = 2'h2;
  localparam logic [1:0] RESP_UNSUPPORTED = 2'h3;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;
  localparam int WAIT_WIDTH = 20;
  typedef enum logic [4:0] {
    UVR_OFF = 5'h01,
    UVR_RUN = 5'h02,
    UVR_DELAY = 5'h04,
    UVR_LATCHED = 5'h08,
    UVR_RETRY = 5'h10
  } uvr_state_t;
endpackage
`default_nettype wire

// ---- testbench/test_vout_undervoltage_fault_response.sv ----
`default_nettype none
module test_vout_undervoltage_fault_response
  import uvr_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  // Short persistence step keeps the delay and retry scenarios quick
  localparam int STEP = 4;
  localparam int CYCLE_LIMIT = 3000;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic respWrite, clearFaults, runPin, operationOn, uvDetect, rampActive, otherFaultNoRetry;
  logic [7:0] respWriteData, undervoltage_response_byte, retryInterval;
  logic outputEnable, uvFaultBit, cmlFault, smbAlertOut, smbAlertOe;
  int nMismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  int rFast, rSlow;
  // Row: written byte, expected stored byte, expected refusal pulse
  logic [16:0] rows [6] = '{{8'h00, 8'h00, 1'b0}, {8'h43, 8'h43, 1'b0},
    {8'hC0, 8'h43, 1'b1}, {8'h80, 8'h80, 1'b0}, {8'hFF, 8'h80, 1'b1}, {8'hBF, 8'hBF, 1'b0}};
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == CYCLE_LIMIT) begin
      nMismatch++;
      finalReport();
    end
  end
  uvr_host u_host (.sys_clk(sys_clk), .respWrite(respWrite), .respWriteData(respWriteData),
    .clearFaults(clearFaults));
  uvr_fault_response #(.DELAY_STEP(STEP)) u_dut (.sys_clk(sys_clk), .nrst(nrst),
    .respWrite(respWrite), .respWriteData(respWriteData),
    .undervoltage_response_byte(undervoltage_response_byte), .clearFaults(clearFaults),
    .runPin(runPin), .operationOn(operationOn), .uvDetect(uvDetect), .rampActive(rampActive),
    .otherFaultNoRetry(otherFaultNoRetry), .retry_interval_setting(retryInterval),
    .outputEnable(outputEnable), .uvFaultBit(uvFaultBit), .cmlFault(cmlFault),
    .smbAlertOut(smbAlertOut), .smbAlertOe(smbAlertOe));
  function automatic logic [7:0] flags();
    return {4'h0, outputEnable, uvFaultBit, smbAlertOe, smbAlertOut};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      nMismatch++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic count_rises(input int n, output int r);
    logic prev;
    r = 0;
    prev = outputEnable;
    repeat (n) begin
      @(negedge sys_clk);
      if (outputEnable === 1'b1 && prev === 1'b0) r++;
      prev = outputEnable;
    end
  endtask
  task automatic finalReport();
    $display("comparisons %0d mismatches %0d", comparisons, nMismatch);
    if (nMismatch == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    {runPin, operationOn, uvDetect, rampActive, otherFaultNoRetry} = 5'h00;
    retryInterval = 8'h02;
    cyc(2);
    chk(flags(), 8'h00, "reset flags");
    chk(undervoltage_response_byte, RESP_BYTE_RESET, "reset byte");
    nrst = 1'b1;
    for (int i = 0; i < 6; i++) begin
      u_host.put(rows[i][16:9]);
      chk(undervoltage_response_byte, rows[i][8:1], "stored byte");
      chk({7'h00, cmlFault}, {7'h00, rows[i][0]}, "refusal pulse");
    end
    $display("test config done");
    u_host.put(8'h00);
    {runPin, operationOn} = 2'h3;
    cyc(6);
    chk(flags(), 8'h08, "running");
    uvDetect = 1'b1;
    cyc(6);
    chk(flags(), 8'h0E, "fault ignored but reported");
    uvDetect = 1'b0;
    cyc(4);
    chk(flags(), 8'h0E, "bit sticky");
    u_host.clr();
    cyc(1);
    chk(flags(), 8'h08, "bit cleared");
    $display("test ignore done");
    u_host.put(8'h80);
    rampActive = 1'b1;
    uvDetect = 1'b1;
    cyc(6);
    chk(flags(), 8'h08, "masked in ramp");
    uvDetect = 1'b0;
    cyc(4);
    rampActive = 1'b0;
    uvDetect = 1'b1;
    cyc(4);
    chk(flags(), 8'h06, "shutdown");
    uvDetect = 1'b0;
    cyc(20);
    chk(flags(), 8'h06, "no restart");
    u_host.clr();
    cyc(2);
    chk(flags(), 8'h08, "restart on clear");
    $display("test shutdown done");
    u_host.put(8'h43);
    uvDetect = 1'b1;
    // Detection lands two edges after the pin moves, then 3 steps of persistence
    cyc(3 * STEP + 2);
    chk(flags(), 8'h0E, "runs during delay");
    cyc(3);
    chk(flags(), 8'h06, "off after delay");
    uvDetect = 1'b0;
    runPin = 1'b0;
    cyc(4);
    chk(flags(), 8'h06, "bit kept while off");
    runPin = 1'b1;
    cyc(6);
    chk(flags(), 8'h08, "pin toggle clears");
    operationOn = 1'b0;
    uvDetect = 1'b1;
    cyc(6);
    chk(flags(), 8'h00, "masked when inactive");
    uvDetect = 1'b0;
    operationOn = 1'b1;
    cyc(6);
    $display("test delay done");
    u_host.put(8'hB8);
    uvDetect = 1'b1;
    count_rises(80, rFast);
    chk({7'h00, 1'(rFast >= 3)}, 8'h01, "continuous retry");
    retryInterval = 8'h06;
    count_rises(80, rSlow);
    chk({7'h00, 1'(rFast > rSlow)}, 8'h01, "retry wait follows interval");
    otherFaultNoRetry = 1'b1;
    cyc(40);
    count_rises(60, rFast);
    chk(rFast[7:0], 8'h00, "retry stopped");
    {otherFaultNoRetry, uvDetect, operationOn} = 3'h0;
    cyc(3);
    operationOn = 1'b1;
    cyc(6);
    chk(flags(), 8'h08, "operation toggle clears");
    $display("test retry done");
    // Delayed response with continuous retry, longest delay code
    retryInterval = 8'h02;
    u_host.put(8'h7F);
    uvDetect = 1'b1;
    cyc(7 * STEP + 2);
    chk(flags(), 8'h0E, "longest delay still running");
    cyc(3);
    chk(flags(), 8'h06, "delay expiry shuts down");
    count_rises(2 * STEP + 4, rFast);
    chk(rFast[7:0], 8'h01, "restart after delay");
    $display("test delayed retry done");
    nrst = 1'b0;
    cyc(2);
    chk(flags(), 8'h00, "flags in mid-run reset");
    chk(undervoltage_response_byte, RESP_BYTE_RESET, "byte in mid-run reset");
    uvDetect = 1'b0;
    nrst = 1'b1;
    cyc(1);
    chk(flags(), 8'h00, "first edge after reset");
    cyc(6);
    chk(flags(), 8'h08, "runs after reset");
    $display("test reset done");
    finalReport();
  end
endmodule
`default_nettype wire

// ---- testbench/uvr_host.sv ----
`default_nettype none
module uvr_host (
  input wire logic sys_clk,
  output logic respWrite,
  output logic [7:0] respWriteData,
  output logic clearFaults
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    respWrite = 1'b0;
    respWriteData = 8'hA5;
    clearFaults = 1'b0;
  end
  task automatic put(input logic [7:0] d);
    @(negedge sys_clk);
    respWrite = 1'b1;
    respWriteData = d;
    @(negedge sys_clk);
    respWrite = 1'b0;
    // Stale data flipped so a late capture shows up
    respWriteData = ~d;
  endtask
  task automatic clr();
    @(negedge sys_clk);
    clearFaults = 1'b1;
    @(negedge sys_clk);
    clearFaults = 1'b0;
  endtask
endmodule
`default_nettype wire
